// ==== logic/fsrh_bus_cycle.sv ====
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`include "fsrh_consts.svh"

module fsrh_bus_cycle #(
	parameter int unsigned STROBE_CYC = `FSRH_STROBE_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire fsrh_pkg::fsrh_bus_t req,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_data,
	output logic done,
	output logic [15:0] rd_data,
	output logic [15:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe_n,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n
);
	import fsrh_pkg::*;

	typedef struct packed {
		logic busy;
		logic wr;
		logic [7:0] cnt;
		logic [15:0] addr;
		logic [15:0] dout;
		logic [15:0] din;
		logic done;
	} fsrh_cyc_state_t;

	fsrh_cyc_state_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		if (!st_q.busy) begin
			// Idle cycle after done, so a request still held is not taken twice
			if (req != FSRH_BUS_IDLE && !st_q.done) begin
				st_d.busy = 1'b1;
				st_d.wr = (req == FSRH_BUS_WR);
				st_d.addr = req_addr;
				st_d.dout = req_data;
				st_d.cnt = 8'(STROBE_CYC);
			end
		end else if (st_q.cnt != 8'h00) begin
			st_d.cnt = st_q.cnt - 8'h01;
		end else begin
			// Read data sampled here, at the end of the read strobe
			if (!st_q.wr)
				st_d.din = flash_dq_in;
			st_d.busy = 1'b0;
			st_d.done = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign done = st_q.done;
	assign rd_data = st_q.din;
	assign flash_addr = st_q.addr;
	assign flash_dq_out = st_q.dout;
	assign flash_dq_oe_n = !(st_q.busy && st_q.wr);
	assign flash_ce_n = !st_q.busy;
	assign flash_we_n = !(st_q.busy && st_q.wr && st_q.cnt != 8'h00);
	assign flash_oe_n = !(st_q.busy && !st_q.wr);
endmodule : fsrh_bus_cycle

// ==== logic/fsrh_consts.svh ====
// Constants for the flash suspend/resume status host controller
// Functional notes
// - After erase suspend: resume, toggle check first
// - Erase resume valid suspended; spacing before suspend
// - After program suspend: resume, toggle check first
// - Program resume valid suspended; spacing before suspend
// - Blank check: write 33h at 555h
// - Polling bit complements data; recheck after timeout
// - Toggle bit toggles while busy; read twice
// - Host waits ready before any suspend
`ifndef FSRH_CONSTS_SVH
`define FSRH_CONSTS_SVH

// APB register offsets
`define FSRH_REG_CMD 12'h000
`define FSRH_REG_ADDR 12'h004
`define FSRH_REG_WDATA 12'h008
`define FSRH_REG_STAT 12'h00C
`define FSRH_REG_RDATA 12'h010
`define FSRH_REG_EXT 12'h014
`define FSRH_REG_CTRL 12'h018

// Flash command codes
`define FSRH_CODE_ERS_SUSP 16'h00B0
`define FSRH_CODE_ERS_RES 16'h0030
`define FSRH_CODE_PRG_SUSP 16'h0051
`define FSRH_CODE_PRG_RES 16'h0050
`define FSRH_CODE_BLANK 16'h0033
`define FSRH_ADDR_BLANK 16'h0555
`define FSRH_CODE_XSR_RD 16'h0075
`define FSRH_CODE_XSR_CLR 16'h0071
`define FSRH_CODE_RESET 16'h00F0

// Extended status field positions
`define FSRH_XSR_READY 7
`define FSRH_XSR_ESUSP 6
`define FSRH_XSR_EFAIL 5
`define FSRH_XSR_PFAIL 4
`define FSRH_XSR_ABORT 3
`define FSRH_XSR_PSUSP 2
`define FSRH_XSR_LOCK 1

// Legacy status bit positions
`define FSRH_Q_POLL 7
`define FSRH_Q_TOGGLE 6
`define FSRH_Q_TIMEOUT 5
`define FSRH_Q_ABORT 1

// Timing, 40 MHz system clock
`define FSRH_CLK_MHZ 40
`define FSRH_STROBE_NS 50
`define FSRH_STROBE_CYC ((`FSRH_STROBE_NS * `FSRH_CLK_MHZ + 999) / 1000)
`define FSRH_TERS_US 100
`define FSRH_TERS_CYC (`FSRH_TERS_US * `FSRH_CLK_MHZ)
`define FSRH_TPRS_US 5
`define FSRH_TPRS_CYC (`FSRH_TPRS_US * `FSRH_CLK_MHZ)

`endif

// ==== logic/fsrh_host.sv ====
// Host controller: suspend/resume, blank check and status polling of a parallel NOR flash
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fsrh_consts.svh"

module fsrh_host #(
	parameter int unsigned TERS_CYC = `FSRH_TERS_CYC,
	parameter int unsigned TPRS_CYC = `FSRH_TPRS_CYC,
	parameter int unsigned STROBE_CYC = `FSRH_STROBE_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe_n,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	input wire logic ready_busy_pin
);
	import fsrh_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ISSUE,
		S_READ,
		S_POLL1,
		S_POLL2,
		S_FINISH
	} fsrh_st_t;

	typedef struct packed {
		fsrh_st_t st;
		fsrh_op_t op;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [15:0] xsr;
		logic [15:0] first;
		logic xsr_pend;
		logic busy;
		logic op_done;
		logic cmd_refused;
		logic poll_running;
		logic esusp;
		logic psusp;
		logic [31:0] ers_gap;
		logic [31:0] prg_gap;
	} fsrh_state_t;

	fsrh_state_t s_q, s_d;
	fsrh_bus_t bus_req;
	logic [15:0] bus_addr;
	logic [15:0] bus_data;
	logic bus_done;
	logic [15:0] bus_rd;
	logic wr_acc;
	fsrh_op_t new_op;

	// ----------------------------------------------------------------
	// Command code decode
	// ----------------------------------------------------------------
	function automatic logic [15:0] op_code(input fsrh_op_t op, input logic [15:0] wd);
		case (op)
			FSRH_OP_ERS_SUSP: op_code = `FSRH_CODE_ERS_SUSP;
			FSRH_OP_ERS_RES: op_code = `FSRH_CODE_ERS_RES;
			FSRH_OP_PRG_SUSP: op_code = `FSRH_CODE_PRG_SUSP;
			FSRH_OP_PRG_RES: op_code = `FSRH_CODE_PRG_RES;
			FSRH_OP_BLANK: op_code = `FSRH_CODE_BLANK;
			FSRH_OP_XSR_RD: op_code = `FSRH_CODE_XSR_RD;
			FSRH_OP_XSR_CLR: op_code = `FSRH_CODE_XSR_CLR;
			FSRH_OP_RESET: op_code = `FSRH_CODE_RESET;
			default: op_code = wd;
		endcase
	endfunction : op_code

	// Blank check targets 555h inside the chosen sector
	function automatic logic [15:0] op_addr(input fsrh_op_t op, input logic [15:0] a);
		if (op == FSRH_OP_BLANK)
			op_addr = {a[15:12], 12'(`FSRH_ADDR_BLANK)};
		else
			op_addr = a;
	endfunction : op_addr

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign pready = 1'b1;
	assign wr_acc = psel && penable && pwrite;
	assign new_op = fsrh_op_t'(pwdata[3:0]);

	always_comb begin
		pslverr = 1'b0;
		prdata = 32'h0000_0000;
		case (paddr)
			`FSRH_REG_CMD: prdata = {28'h000_0000, s_q.op};
			`FSRH_REG_ADDR: prdata = {16'h0000, s_q.addr};
			`FSRH_REG_WDATA: prdata = {16'h0000, s_q.wdata};
			`FSRH_REG_STAT: prdata = {26'h000_0000, ready_busy_pin, s_q.psusp, s_q.esusp,
				s_q.poll_running, s_q.cmd_refused, s_q.op_done};
			`FSRH_REG_RDATA: prdata = {16'h0000, s_q.rdata};
			`FSRH_REG_EXT: prdata = {16'h0000, s_q.xsr};
			`FSRH_REG_CTRL: prdata = {31'h0000_0000, s_q.busy};
			default: pslverr = psel && penable;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		bus_req = FSRH_BUS_IDLE;
		bus_addr = s_q.addr;
		bus_data = op_code(s_q.op, s_q.wdata);
		if (s_q.ers_gap != 32'h0)
			s_d.ers_gap = s_q.ers_gap - 32'h1;
		if (s_q.prg_gap != 32'h0)
			s_d.prg_gap = s_q.prg_gap - 32'h1;
		if (wr_acc) begin
			case (paddr)
				`FSRH_REG_ADDR: s_d.addr = pwdata[15:0];
				`FSRH_REG_WDATA: s_d.wdata = pwdata[15:0];
				`FSRH_REG_STAT: begin
					// Write one to clear; a same-cycle completion wins below
					if (pwdata[0])
						s_d.op_done = 1'b0;
					if (pwdata[1])
						s_d.cmd_refused = 1'b0;
				end
				default: begin
				end
			endcase
		end
		case (s_q.st)
			S_IDLE: begin
				if (wr_acc && paddr == `FSRH_REG_CMD) begin
					s_d.op = new_op;
					s_d.busy = 1'b1;
					s_d.st = S_ISSUE;
					// Suspend only when ready; not within the resume spacing
					if ((new_op == FSRH_OP_ERS_SUSP && (!ready_busy_pin || s_q.ers_gap != 32'h0))
						|| (new_op == FSRH_OP_PRG_SUSP && (!ready_busy_pin || s_q.prg_gap != 32'h0))
						|| (new_op == FSRH_OP_ERS_RES && !s_q.esusp)
						|| (new_op == FSRH_OP_PRG_RES && !s_q.psusp)
						|| (new_op == FSRH_OP_BLANK && (s_q.esusp || s_q.psusp))) begin
						s_d.cmd_refused = 1'b1;
						s_d.busy = 1'b0;
						s_d.st = S_IDLE;
					end else if (new_op == FSRH_OP_WRITE && (s_q.esusp || s_q.psusp)
						&& s_q.wdata[15:8] != 8'h00) begin
						// Erase or program start while suspended is held back
						s_d.cmd_refused = 1'b1;
						s_d.busy = 1'b0;
						s_d.st = S_IDLE;
					end else if (new_op == FSRH_OP_READ) begin
						s_d.st = S_READ;
					end else if (new_op == FSRH_OP_POLL) begin
						s_d.st = S_POLL1;
					end
				end
			end
			S_ISSUE: begin
				bus_req = FSRH_BUS_WR;
				bus_addr = op_addr(s_q.op, s_q.addr);
				if (bus_done) begin
					case (s_q.op)
						FSRH_OP_ERS_SUSP: s_d.esusp = 1'b1;
						FSRH_OP_PRG_SUSP: s_d.psusp = 1'b1;
						FSRH_OP_ERS_RES: begin
							s_d.esusp = 1'b0;
							s_d.ers_gap = TERS_CYC;
						end
						FSRH_OP_PRG_RES: begin
							s_d.psusp = 1'b0;
							s_d.prg_gap = TPRS_CYC;
						end
						FSRH_OP_XSR_RD: s_d.xsr_pend = 1'b1;
						default: begin
						end
					endcase
					// Resume only: confirm running by toggle; blank check finishes at once
					if (s_q.op == FSRH_OP_ERS_RES || s_q.op == FSRH_OP_PRG_RES)
						s_d.st = S_POLL1;
					else if (s_q.op == FSRH_OP_XSR_RD)
						s_d.st = S_READ;
					else
						s_d.st = S_FINISH;
				end
			end
			S_READ: begin
				bus_req = FSRH_BUS_RD;
				if (bus_done) begin
					s_d.rdata = bus_rd;
					if (s_q.xsr_pend) begin
						// Reserved bits dropped; 6..1 only meaningful when ready
						s_d.xsr = {8'h00, bus_rd[7:1], 1'b0};
						s_d.xsr_pend = 1'b0;
					end
					s_d.st = S_FINISH;
				end
			end
			S_POLL1: begin
				bus_req = FSRH_BUS_RD;
				if (bus_done) begin
					s_d.first = bus_rd;
					s_d.st = S_POLL2;
				end
			end
			S_POLL2: begin
				// Two reads; toggle compared, timeout rise rechecked for FSRH_OP_POLL only, not after a resume
				bus_req = FSRH_BUS_RD;
				if (bus_done) begin
					s_d.rdata = bus_rd;
					if (bus_rd[`FSRH_Q_TOGGLE] != s_q.first[`FSRH_Q_TOGGLE]) begin
						s_d.poll_running = 1'b1;
						if (bus_rd[`FSRH_Q_TIMEOUT] && s_q.op == FSRH_OP_POLL)
							s_d.st = S_POLL1;
						else
							s_d.st = S_FINISH;
					end else begin
						s_d.poll_running = 1'b0;
						s_d.st = S_FINISH;
					end
				end
			end
			S_FINISH: begin
				s_d.op_done = 1'b1;
				s_d.busy = 1'b0;
				s_d.st = S_IDLE;
			end
			default: s_d.st = S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	fsrh_bus_cycle #(
		.STROBE_CYC(STROBE_CYC)
	) u_cycle (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.req(bus_req),
		.req_addr(bus_addr),
		.req_data(bus_data),
		.done(bus_done),
		.rd_data(bus_rd),
		.flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe_n(flash_dq_oe_n),
		.flash_dq_in(flash_dq_in),
		.flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n),
		.flash_oe_n(flash_oe_n)
	);
endmodule : fsrh_host

// ==== logic/fsrh_pkg.sv ====
// Types for the flash suspend/resume status host controller
package fsrh_pkg;
	typedef enum logic [3:0] {
		FSRH_OP_NONE,
		FSRH_OP_WRITE,
		FSRH_OP_READ,
		FSRH_OP_ERS_SUSP,
		FSRH_OP_ERS_RES,
		FSRH_OP_PRG_SUSP,
		FSRH_OP_PRG_RES,
		FSRH_OP_BLANK,
		FSRH_OP_XSR_RD,
		FSRH_OP_XSR_CLR,
		FSRH_OP_RESET,
		FSRH_OP_POLL
	} fsrh_op_t;

	typedef enum logic [1:0] {
		FSRH_BUS_IDLE,
		FSRH_BUS_WR,
		FSRH_BUS_RD
	} fsrh_bus_t;
endpackage : fsrh_pkg

// ==== tb/fsrh_flash_model.sv ====
// Behavioural NOR flash device facing the host controller
`timescale 1ns/1ps
module fsrh_flash_model #(
	parameter int SUSP_NS = 300
) (
	input wire logic [15:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe_n,
	output logic [15:0] flash_dq_in,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	output logic ready_busy_pin
);
	// ----
	// State: 0 read, 1 erase, 2 program, 3 erase held, 4 program held, 5 blank check
	// ----
	logic [2:0] st = 3'd0;
	logic [3:0] sec = 4'h0;
	logic rdy = 1'b1, tog = 1'b0, cap_v = 1'b0, shw = 1'b0, q2 = 1'b0;
	logic [15:0] xsr = 16'h0080, cap = 16'h0000, val;
	wire busy = st == 3'd1 || st == 3'd2 || st == 3'd5;
	wire hit = flash_addr[15:12] == sec;
	assign ready_busy_pin = rdy;
	// Suspended erase sector shows status, suspended program sector junk
	// Abort indicator, bit 1, stays low: no buffer abort while running
	assign val = shw ? cap
		: (st == 3'd3 && hit) ? {8'h00, 1'b1, 4'h0, q2, 2'b00}
		: (st == 3'd4 && hit) ? 16'h0000
		: busy ? {9'h000, tog, 3'h0, q2 && st == 3'd1, 1'b0, 1'b0} : 16'hFFFF;
	always @(posedge flash_oe_n) begin
		if ((st == 3'd1 || st == 3'd3) && hit) q2 = ~q2;
	end
	assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? val : ~val;
	always @(negedge flash_oe_n) begin
		shw = cap_v;
		cap_v = 1'b0;
		if (busy) tog = ~tog;
	end
	always @(posedge flash_we_n) begin
		if (!flash_ce_n) begin
			case (flash_dq_out)
			16'h00B0: if (st == 3'd1) begin
				#(SUSP_NS);
				st = 3'd3;
				xsr[6] = 1'b1;
			end
			16'h0030: if (st == 3'd3) begin
				st = 3'd1;
				xsr[6] = 1'b0;
			end
			16'h0051: if (st == 3'd2) begin
				#(SUSP_NS);
				st = 3'd4;
				xsr[2] = 1'b1;
			end
			16'h0050: if (st == 3'd4) begin
				st = 3'd2;
				xsr[2] = 1'b0;
			end
			16'h0033: if (st == 3'd0 && flash_addr[10:0] == 11'h555) st = 3'd5;
			16'h0075: begin
				cap = {xsr[15:8], !busy, xsr[6:0]};
				cap_v = 1'b1;
			end
			16'h0071, 16'h00F0: if (!busy) xsr = xsr & 16'hFFC5;
			default: if (st == 3'd3 && hit) xsr[4] = 1'b1;
			endcase
		end
	end
endmodule : fsrh_flash_model

// ==== tb/fsrh_host_assertions.sv ====
// Port checker for the flash host controller
`timescale 1ns/1ps
module fsrh_host_assertions #(
	parameter int unsigned TERS_CYC = 4000,
	parameter int unsigned TPRS_CYC = 200
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [15:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	input wire logic ready_busy_pin
);
	// ----
	// Command edge and resume spacing counters
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic we_q;
	logic [31:0] ers_gap_q, prg_gap_q;
	wire cmd_wr = we_q && !flash_we_n;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			we_q <= 1'b1;
			ers_gap_q <= '1;
			prg_gap_q <= '1;
		end else begin
			we_q <= flash_we_n;
			ers_gap_q <= (cmd_wr && flash_dq_out == 16'h0030) ? '0 : ers_gap_q + {31'h0, ~&ers_gap_q};
			prg_gap_q <= (cmd_wr && flash_dq_out == 16'h0050) ? '0 : prg_gap_q + {31'h0, ~&prg_gap_q};
		end
	end
	a_ers_susp_ready: assert property (cmd_wr && flash_dq_out == 16'h00B0 |-> ready_busy_pin)
		else $error("erase suspend sent while busy");
	a_prg_susp_ready: assert property (cmd_wr && flash_dq_out == 16'h0051 |-> ready_busy_pin)
		else $error("program suspend sent while busy");
	a_ers_resume_gap: assert property (cmd_wr && flash_dq_out == 16'h00B0 |-> ers_gap_q >= TERS_CYC)
		else $error("erase suspend too soon after resume");
	a_prg_resume_gap: assert property (cmd_wr && flash_dq_out == 16'h0051 |-> prg_gap_q >= TPRS_CYC)
		else $error("program suspend too soon after resume");
	a_blank_addr: assert property (cmd_wr && flash_dq_out == 16'h0033 |-> flash_addr[10:0] == 11'h555)
		else $error("blank check at wrong address");
	a_ers_res_check: assert property (cmd_wr && flash_dq_out == 16'h0030 |-> ##[1:12] !flash_oe_n)
		else $error("no status read after erase resume");
	a_prg_res_check: assert property (cmd_wr && flash_dq_out == 16'h0050 |-> ##[1:12] !flash_oe_n)
		else $error("no status read after program resume");
	a_write_strobe: assert property ($fell(flash_we_n) |->
		(!flash_ce_n && flash_oe_n && !flash_we_n)[*2] ##1 (flash_we_n && !flash_ce_n))
		else $error("bad write strobe shape");
endmodule : fsrh_host_assertions

// ==== tb/tb.sv ====
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb;
	logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n, ready_busy_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, st;
	logic [15:0] flash_addr, flash_dq_out, flash_dq_in;
	int n_fail, n_tests;
	fsrh_host #(.TERS_CYC(400), .TPRS_CYC(200)) i_dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_dq_out, .flash_dq_oe_n, .flash_dq_in,
		.flash_ce_n, .flash_we_n, .flash_oe_n, .ready_busy_pin);
	fsrh_flash_model i_flash (.flash_addr, .flash_dq_out, .flash_dq_oe_n, .flash_dq_in, .flash_ce_n,
		.flash_we_n, .flash_oe_n, .ready_busy_pin);
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", n_fail, n_tests);
		if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic die;
		chk(32'h0, 32'h1);
		report_and_stop();
	endtask : die
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) die();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic run(input logic [3:0] op);
		int i;
		apb(1'b1, 12'h000, {28'h0, op});
		rd = '0;
		for (i = 0; i < 400 && rd[1:0] === 2'b00; i++) apb(1'b0, 12'h00C, 32'h0);
		if (rd[1:0] === 2'b00 || rd[1:0] === 2'bxx) die();
		st = rd;
		apb(1'b1, 12'h00C, 32'h3);
	endtask : run
	// ----
	// Scenarios
	// ----
	task automatic s_basic;
		apb(1'b0, 12'h018, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h01C, 32'h0);
		chk({31'h0, err}, 32'h1);
		run(4'd1);
		chk({31'h0, st[1]}, 32'h0);
		run(4'd2);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h0000FFFF);
		run(4'd11);
		chk({31'h0, st[2]}, 32'h0);
	endtask : s_basic
	task automatic s_suspend;
		int k;
		logic q;
		for (k = 0; k < 2; k++) begin
			i_flash.st = 3'(1 + k);
			i_flash.rdy = 1'b0;
			run(4'(3 + 2 * k));
			chk({31'h0, st[1]}, 32'h1);
			i_flash.rdy = 1'b1;
			run(4'(3 + 2 * k));
			repeat (16) @(posedge sys_clk);
			chk({28'h0, st[1], i_flash.st}, {28'h0, 1'b0, 3'(3 + k)});
			chk({31'h0, st[3 + k]}, 32'h1);
			if (k == 0) begin
				apb(1'b1, 12'h008, 32'h00001200);
				run(4'd1);
				chk({31'h0, st[1]}, 32'h1);
				apb(1'b1, 12'h008, 32'h00000012);
				run(4'd1);
				run(4'd8);
				apb(1'b0, 12'h014, 32'h0);
				chk(rd, 32'h000000D0);
				run(4'd2);
				apb(1'b0, 12'h010, 32'h0);
				chk(rd & 32'hFFFFFFFB, 32'h00000080);
				q = rd[2];
				run(4'd2);
				apb(1'b0, 12'h010, 32'h0);
				chk({31'h0, rd[2]}, {31'h0, ~q});
				apb(1'b1, 12'h004, 32'h00001000);
				run(4'd2);
				apb(1'b0, 12'h010, 32'h0);
				chk(rd, 32'h0000FFFF);
			end
			run(4'(4 + 2 * k));
			chk({28'h0, st[3 + k], i_flash.st}, {28'h0, 1'b0, 3'(1 + k)});
			run(4'(3 + 2 * k));
			chk({31'h0, st[1]}, 32'h1);
			repeat (450) @(posedge sys_clk);
			run(4'(3 + 2 * k));
			repeat (16) @(posedge sys_clk);
			chk({28'h0, st[1], i_flash.st}, {28'h0, 1'b0, 3'(3 + k)});
			run(4'(4 + 2 * k));
			run(4'(4 + 2 * k));
			chk({31'h0, st[1]}, 32'h1);
		end
		i_flash.st = 3'd0;
	endtask : s_suspend
	task automatic s_status;
		apb(1'b1, 12'h004, 32'h00003555);
		run(4'd7);
		chk({29'h0, i_flash.st}, 32'h5);
		i_flash.st = 3'd0;
		i_flash.xsr = 16'hFFFF;
		run(4'd8);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h000000FE);
		run(4'd9);
		run(4'd8);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h000000C4);
		i_flash.xsr = 16'h00BA;
		run(4'd10);
		run(4'd8);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h00000080);
	endtask : s_status
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		n_fail = 0;
		n_tests = 0;
		arst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		s_basic();
		s_suspend();
		s_status();
		report_and_stop();
	end
endmodule : tb
bind fsrh_host fsrh_host_assertions #(.TERS_CYC(TERS_CYC), .TPRS_CYC(TPRS_CYC)) i_chk (.sys_clk, .arst_n,
	.flash_addr, .flash_dq_out, .flash_ce_n, .flash_we_n, .flash_oe_n, .ready_busy_pin);
